// ---- hps_pkg.sv ----
// Purpose: constants shared by the hot-plug slot control pin logic
// Assumes: one clock, synchronous pin inputs
// Notes: slot output registers change only under software control or reset; card present and events follow the pins
//
// Overview of operation
// [RULE1] card present when either presence pin low
// [RULE2] enabled power fault raises interrupt
// [RULE3] enabled power good raises interrupt
// [RULE4] per-slot power output from control bit
// [RULE5] request switch control follows software setting
// [RULE6] wide request driven beside reset, software set
// [RULE7] wide card in narrow slot quiets upper inputs; no logic here quiets any inputs
// [RULE8] slot bus reset under software control only
// [RULE9] power bit high drives power output high
// [RULE10] wide request low for 64, high for 32
// [RULE11] reset: unpowered, slot reset on, switch off
package hps_pkg;

  // ************************************************
  // reset values of the slot outputs, and the default slot count
  // ************************************************
  localparam logic RST_POWER = 1'b0;
  localparam logic RST_SLOT_RESET_N = 1'b0;
  localparam logic RST_SWITCH = 1'b0;
  localparam logic RST_WIDE_REQ = 1'b1;
  localparam int NUM_SLOTS = 4;

endpackage

// ---- hps_slot.sv ----
// Purpose: per-slot output registers and event detection
// Assumes: inputs synchronous to clk, reset already synchronised
// Notes: event edges are sampled, not filtered
`timescale 1ns/1ps
module hps_slot
  import hps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic presence_a,
  input wire logic presence_b,
  input wire logic power_fault_in,
  input wire logic power_ok_in,
  input wire logic power_ctl_bit,
  input wire logic slot_reset_ctl_n,
  input wire logic wide_switch_ctl_bit,
  input wire logic slot_is_32,
  input wire logic fault_irq_en,
  input wire logic good_irq_en,
  output logic card_present,
  output logic fault_event,
  output logic good_event,
  output logic slot_power_out,
  output logic slot_bus_reset_n,
  output logic wide_req_switch_ctl,
  output logic slot_wide_request
);

  // ************************************************
  // event edges
  // ************************************************
  logic fault_d_reg;
  logic good_d_reg;
  wire fault_rise = power_fault_in & ~fault_d_reg;
  wire good_rise = power_ok_in & ~good_d_reg;

  // card grounds only one pin, so either low counts
  assign card_present = ~presence_a | ~presence_b; // RULE1
  // rising edge only: a held fault does not retrigger
  assign fault_event = fault_rise & fault_irq_en; // RULE2
  assign good_event = good_rise & good_irq_en; // RULE3

  // input history for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_d_reg <= 1'b0;
      good_d_reg <= 1'b0;
    end else begin
      fault_d_reg <= power_fault_in;
      good_d_reg <= power_ok_in;
    end
  end

  // ************************************************
  // output registers, software driven only
  // ************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_power_out <= RST_POWER; // RULE11
      slot_bus_reset_n <= RST_SLOT_RESET_N; // RULE11
      wide_req_switch_ctl <= RST_SWITCH; // RULE11
      slot_wide_request <= RST_WIDE_REQ;
    end else begin
      slot_power_out <= power_ctl_bit; // RULE4 RULE9
      slot_bus_reset_n <= slot_reset_ctl_n; // RULE8
      wide_req_switch_ctl <= wide_switch_ctl_bit; // RULE5
      // low tells the card the slot is 64-bit wide
      slot_wide_request <= slot_is_32; // RULE6 RULE10
    end
  end

endmodule

// ---- hps_top.sv ----
// Purpose: hot-plug slot control and status pins for several slots
// Assumes: control bits come from software-held flops outside
// Notes: interrupt is a level held until the clear strobe
`timescale 1ns/1ps
module hps_top
  import hps_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [SLOTS-1:0] presence_a,
  input wire logic [SLOTS-1:0] presence_b,
  input wire logic [SLOTS-1:0] power_fault_in,
  input wire logic [SLOTS-1:0] power_ok_in,
  input wire logic [SLOTS-1:0] power_ctl_bit,
  input wire logic [SLOTS-1:0] slot_reset_ctl_n,
  input wire logic [SLOTS-1:0] wide_switch_ctl_bit,
  input wire logic [SLOTS-1:0] slot_is_32,
  input wire logic [SLOTS-1:0] fault_irq_en,
  input wire logic [SLOTS-1:0] good_irq_en,
  input wire logic [SLOTS-1:0] fault_clear,
  input wire logic [SLOTS-1:0] good_clear,
  output logic [SLOTS-1:0] card_present,
  output logic [SLOTS-1:0] fault_status,
  output logic [SLOTS-1:0] good_status,
  output logic irq_out,
  output logic [SLOTS-1:0] slot_power_out,
  output logic [SLOTS-1:0] slot_bus_reset_n,
  output logic [SLOTS-1:0] wide_req_switch_ctl,
  output logic [SLOTS-1:0] slot_wide_request
);

  // ************************************************
  // reset release
  // ************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  // async assert, synchronous release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ************************************************
  // slots
  // ************************************************
  logic [SLOTS-1:0] fault_event;
  logic [SLOTS-1:0] good_event;
  logic [SLOTS-1:0] fault_next;
  logic [SLOTS-1:0] good_next;

  genvar i;
  generate
    for (i = 0; i < SLOTS; i++) begin : g_slot
      hps_slot u_slot (
        .clk(clk),
        .rst_n(rst_n_reg),
        .presence_a(presence_a[i]),
        .presence_b(presence_b[i]),
        .power_fault_in(power_fault_in[i]),
        .power_ok_in(power_ok_in[i]),
        .power_ctl_bit(power_ctl_bit[i]),
        .slot_reset_ctl_n(slot_reset_ctl_n[i]),
        .wide_switch_ctl_bit(wide_switch_ctl_bit[i]),
        .slot_is_32(slot_is_32[i]),
        .fault_irq_en(fault_irq_en[i]),
        .good_irq_en(good_irq_en[i]),
        .card_present(card_present[i]),
        .fault_event(fault_event[i]),
        .good_event(good_event[i]),
        .slot_power_out(slot_power_out[i]),
        .slot_bus_reset_n(slot_bus_reset_n[i]),
        .wide_req_switch_ctl(wide_req_switch_ctl[i]),
        .slot_wide_request(slot_wide_request[i])
      );
    end
  endgenerate

  // ************************************************
  // sticky status, set wins over clear
  // ************************************************
  assign fault_next = (fault_status & ~fault_clear) | fault_event; // RULE2
  assign good_next = (good_status & ~good_clear) | good_event; // RULE3

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fault_status <= '0;
      good_status <= '0;
      irq_out <= 1'b0;
    end else begin
      fault_status <= fault_next;
      good_status <= good_next;
      irq_out <= |{fault_next, good_next}; // RULE2 RULE3
    end
  end

endmodule

// ---- hps_top_monitor.sv ----
// Purpose: port checker for hps_top
// Assumes: registered outputs lag inputs one edge; card_present does not
// Notes: up hides the two-flop reset delay
`timescale 1ns/1ps
module hps_mon #(parameter int SLOTS = 4)(
  input wire logic clk, reset_n, irq_out,
  input wire logic [SLOTS-1:0] presence_a, presence_b, power_fault_in, power_ok_in, power_ctl_bit, slot_is_32,
  input wire logic [SLOTS-1:0] slot_reset_ctl_n, wide_switch_ctl_bit, fault_irq_en, good_irq_en, card_present,
  input wire logic [SLOTS-1:0] fault_status, good_status, slot_power_out, slot_bus_reset_n, wide_req_switch_ctl,
  input wire logic [SLOTS-1:0] slot_wide_request);
  logic [1:0] up;
  wire run = up == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // edges since release, saturating
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) up <= 2'h0;
    else if (!run) up <= up + 2'h1;
  chk_card_seen: assert property (card_present == ~(presence_a & presence_b)) else $error("pres");
  chk_fault_sets: assert property (run && |(power_fault_in & ~$past(power_fault_in) & fault_irq_en)
    |=> |fault_status && irq_out) else $error("fault");
  chk_good_sets: assert property (run && |(power_ok_in & ~$past(power_ok_in) & good_irq_en)
    |=> |good_status && irq_out) else $error("good");
  chk_power_follow: assert property (run |=> slot_power_out == $past(power_ctl_bit)) else $error("pwr");
  chk_switch_follow: assert property (run |=> wide_req_switch_ctl == $past(wide_switch_ctl_bit))
    else $error("sw");
  chk_wide_follow: assert property (run |=> slot_wide_request == $past(slot_is_32)) else $error("wide");
  chk_reset_follow: assert property (run |=> slot_bus_reset_n == $past(slot_reset_ctl_n)) else $error("rst");
  chk_reset_state: assert property (up < 2'h2 |-> !slot_power_out && !slot_bus_reset_n
    && !wide_req_switch_ctl && &slot_wide_request) else $error("init");
  cover property (irq_out);
  cover property ($fell(irq_out));
  cover property (run && |card_present);
endmodule
bind hps_top hps_mon #(.SLOTS(SLOTS)) mon_u(.*);

// ---- hps_card.sv ----
// Purpose: slot power switch and card model
// Assumes: a card grounds one presence pin
// Notes: power good one edge after switch-on
`timescale 1ns/1ps
module hps_card(
  input wire logic clk,
  input wire logic [3:0] slot_power_out, inserted, fault_cmd,
  output logic [3:0] presence_a, presence_b, power_fault_in, power_ok_in);
  // even slots ground pin a, odd ones pin b
  assign presence_a = ~(inserted & 4'h5);
  assign presence_b = ~(inserted & 4'ha);
  assign power_fault_in = fault_cmd & slot_power_out;
  // power good follows slot power one edge later, held low while a fault is commanded
  always @(posedge clk) power_ok_in <= slot_power_out & ~fault_cmd;
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench for hps_top
// Assumes: hps_card drives the sense pins
// Notes: inputs move on the falling edge
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, reset_n = 0;
  logic [3:0] power_ctl_bit = 0, slot_reset_ctl_n = 0, wide_switch_ctl_bit = 0, slot_is_32 = 0, fault_irq_en = 0;
  logic [3:0] good_irq_en = 0, fault_clear = 0, good_clear = 0, inserted = 0, fault_cmd = 0;
  wire [3:0] presence_a, presence_b, power_fault_in, power_ok_in, card_present, fault_status, good_status;
  wire [3:0] slot_power_out, slot_bus_reset_n, wide_req_switch_ctl, slot_wide_request;
  wire irq_out;
  wire [15:0] outs = {slot_power_out, slot_bus_reset_n, wide_req_switch_ctl, slot_wide_request};
  wire [15:0] evs = {7'h0, irq_out, fault_status, good_status};
  logic [31:0] seed = 32'h9033;
  logic [15:0] notes[$];
  int num_errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  hps_top dut_u(.*);
  hps_card card_u(.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("errors %0d of %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // oldest note against outputs settled after the edge
  always @(posedge clk) begin
    #1;
    if (notes.size() > 0) check(outs, notes.pop_front());
  end
  // hang guard counts as a mismatch
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1;
    check(outs, 16'h000f);
    repeat (3) @(negedge clk);
    repeat (40) begin
      seed = xs(seed);
      {power_ctl_bit, slot_reset_ctl_n, wide_switch_ctl_bit, slot_is_32} = seed[15:0];
      notes.push_back(seed[15:0]);
      @(negedge clk);
    end
    // power every slot down first, so each power-good is a fresh rising edge
    power_ctl_bit = 4'h0;
    repeat (3) @(negedge clk);
    {power_ctl_bit, inserted, fault_irq_en, good_irq_en} = 16'hf615;
    repeat (4) @(negedge clk);
    check({12'h0, card_present}, 16'h0006);
    check(evs, 16'h0105);
    fault_cmd = 4'h3;
    repeat (2) @(negedge clk);
    check(evs, 16'h0115);
    {fault_clear, good_clear} = 8'hff;
    @(negedge clk);
    {fault_clear, good_clear} = 8'h00;
    @(negedge clk);
    check(evs, 16'h0000);
    close_out;
  end
endmodule
